/* File: core/rmsc_clksw.sv */
// Glitch-free clock source and divider switch as enable pulses.
// Assumes every source is presented as a one-cycle tick of CLOCK.
`timescale 1ns/1ps
`default_nettype none
module rmsc_clksw
  import rmsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] src_tick,
  input wire logic [1:0] src_sel,
  input wire logic [1:0] div_sel,
  output logic sys_tick,
  output logic [1:0] cur_src,
  output logic [1:0] cur_div
);
  typedef struct packed {
    logic [1:0] src;
    logic [1:0] div;
    logic [3:0] cnt;
    logic tick;
  } rmsc_sw_t;
  rmsc_sw_t s_q, s_d;

  function automatic logic [3:0] div_mask(input logic [1:0] s,
                                          input logic [1:0] d);
    case ({s, d})
      4'h0, 4'h4, 4'h8, 4'hc: div_mask = 4'h0;
      4'h1, 4'h5, 4'h9: div_mask = 4'h1;
      4'h2: div_mask = 4'h3;
      4'h3, 4'ha: div_mask = 4'h7;
      4'hb: div_mask = 4'hf;
      default: div_mask = 4'h0;
    endcase
  endfunction : div_mask

  always_comb begin
    logic t;
    t = src_tick[s_q.src];
    s_d = s_q;
    s_d.tick = 1'b0;
    if (t) begin
      // Switch only at the end of a full output period
      if ((s_q.cnt & div_mask(s_q.src, s_q.div)) ==
          div_mask(s_q.src, s_q.div)) begin
        s_d.tick = 1'b1;
        s_d.cnt = 4'h0;
        s_d.src = src_sel;
        s_d.div = div_sel;
      end else begin
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sys_tick = s_q.tick;
  assign cur_src = s_q.src;
  assign cur_div = s_q.div;
endmodule : rmsc_clksw
`default_nettype wire

/* File: core/rmsc_pkg.sv */
// Constants for the regulator mode and system clock select block.
// Assumes a 40 MHz single clock and APB access with 32-bit words.
package rmsc_pkg;
  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [11:0] RMSC_ADDR_MODE = 12'h000;
  localparam logic [11:0] RMSC_ADDR_PUMP = 12'h004;
  localparam logic [11:0] RMSC_ADDR_FLAG = 12'h008;
  localparam logic [11:0] RMSC_ADDR_IEN = 12'h00c;
  localparam logic [11:0] RMSC_ADDR_SCLK = 12'h010;
  localparam logic [11:0] RMSC_ADDR_PROT = 12'h014;
  localparam logic [11:0] RMSC_ADDR_OSC = 12'h018;
  localparam logic [11:0] RMSC_ADDR_STAT = 12'h01c;
  localparam logic [15:0] RMSC_UNLOCK_KEY = 16'h0096;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int RMSC_WAKE_EN_BIT = 15;
  localparam int RMSC_WDIV_LSB = 12;
  localparam int RMSC_WSRC_LSB = 8;
  localparam int RMSC_DIV_LSB = 4;
  localparam int RMSC_SLEEP_CONTINUE_BIT_LSB = 8;
  localparam logic [2:0] RMSC_MODE_SECO = 3'h5;
  localparam logic [2:0] RMSC_MODE_ECO = 3'h3;
  localparam logic [2:0] RMSC_MODE_NORM = 3'h2;
  localparam logic [2:0] RMSC_MODE_AUTO = 3'h0;
  localparam logic [3:0] RMSC_OSC_EN_RST = 4'h1;
  localparam logic [3:0] RMSC_SLEEP_CONTINUE_BIT_RST = 4'hf;
  // Cycles a regulator transition takes to settle
  localparam int RMSC_SETTLE_CYC = 16;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    RMSC_SRC_IOSC, RMSC_SRC_OSC1, RMSC_SRC_OSC3, RMSC_SRC_EXT
  } rmsc_src_t;
  typedef enum logic [1:0] {RMSC_IDLE, RMSC_SETTLE} rmsc_tr_t;
endpackage : rmsc_pkg

/* File: core/rmsc_top.sv */
// Regulator mode control and system clock select, APB slave.
// Assumes APB master on CLOCK; sleep and wake are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module rmsc_top
  import rmsc_pkg::*;
#(
  parameter int SETTLE = RMSC_SETTLE_CYC
)(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SLEEP_ENTER,
  input wire logic WAKE_UP,
  input wire logic HIGH_SPEED_RUN,
  input wire logic [3:0] SRC_TICK,
  output logic SYS_TICK,
  output logic PUMP_TICK,
  output logic [2:0] REG_MODE,
  output logic [3:0] OSC_ENABLE,
  output logic IRQ
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] pump;
    logic flag;
    logic ien;
    logic wake_en;
    logic [1:0] wdiv;
    logic [1:0] wsrc;
    logic [1:0] div;
    logic [1:0] src;
    logic unlocked;
    logic [3:0] osc_en;
    logic [3:0] sleep_continue_bit;
    logic asleep;
    logic wake_fix;
    rmsc_tr_t tr;
    logic [7:0] tr_cnt;
    logic from_seco;
    logic [2:0] eff;
    logic [7:0] pcnt;
    logic ptick;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
  } rmsc_st_t;
  rmsc_st_t s_q, s_d;

  logic sys_tick;
  logic [1:0] cur_src;
  logic [1:0] cur_div;

  function automatic logic known_addr(input logic [11:0] a);
    case (a)
      RMSC_ADDR_MODE, RMSC_ADDR_PUMP, RMSC_ADDR_FLAG, RMSC_ADDR_IEN,
      RMSC_ADDR_SCLK, RMSC_ADDR_PROT, RMSC_ADDR_OSC,
      RMSC_ADDR_STAT: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction : known_addr

  function automatic logic [3:0] onehot(input logic [1:0] v);
    onehot = 4'h1 << v;
  endfunction : onehot

  // Mode actually applied: automatic picks normal or economy
  function automatic logic [2:0] eff_mode(input logic [2:0] m,
                                          input logic hs,
                                          input logic sl);
    if (m == RMSC_MODE_AUTO) begin
      eff_mode = (hs && !sl) ? RMSC_MODE_NORM : RMSC_MODE_ECO;
    end else begin
      eff_mode = m;
    end
  endfunction : eff_mode

  // ****************************************************************
  // Clock switch
  // ****************************************************************
  rmsc_clksw u_sw (
    .clk(CLOCK),
    .rst_n(NRST),
    .src_tick(SRC_TICK),
    .src_sel(s_q.src),
    .div_sel(s_q.div),
    .sys_tick(sys_tick),
    .cur_src(cur_src),
    .cur_div(cur_div)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic acc;
    logic wr;
    logic rd;
    logic [2:0] nm;
    logic [7:0] pmask;
    logic done_ev;
    acc = PSEL && PENABLE && !s_q.ready;
    wr = acc && PWRITE && known_addr(PADDR);
    rd = acc && !PWRITE;
    nm = eff_mode(s_q.mode, HIGH_SPEED_RUN, s_q.asleep);
    pmask = 8'h1f;
    done_ev = 1'b0;
    s_d = s_q;
    s_d.ready = acc;
    s_d.err = acc && !known_addr(PADDR);
    s_d.rdata = '0;
    // Protected writes only while the key is present
    if (wr && s_q.unlocked) begin
      case (PADDR)
        RMSC_ADDR_MODE: begin
          case (PWDATA[2:0])
            RMSC_MODE_SECO, RMSC_MODE_ECO, RMSC_MODE_NORM:
              s_d.mode = PWDATA[2:0];
            default: s_d.mode = RMSC_MODE_AUTO;
          endcase
        end
        RMSC_ADDR_PUMP: s_d.pump = PWDATA[1:0];
        RMSC_ADDR_SCLK: begin
          s_d.wake_en = PWDATA[RMSC_WAKE_EN_BIT];
          s_d.wdiv = PWDATA[RMSC_WDIV_LSB +: 2];
          s_d.wsrc = PWDATA[RMSC_WSRC_LSB +: 2];
          s_d.div = PWDATA[RMSC_DIV_LSB +: 2];
          s_d.src = PWDATA[1:0];
          s_d.osc_en = s_q.osc_en | onehot(PWDATA[1:0]);
        end
        default: ;
      endcase
    end
    if (wr) begin
      case (PADDR)
        RMSC_ADDR_IEN: s_d.ien = PWDATA[0];
        RMSC_ADDR_PROT: s_d.unlocked = (PWDATA[15:0] == RMSC_UNLOCK_KEY);
        RMSC_ADDR_OSC: begin
          s_d.osc_en = PWDATA[3:0] | onehot(s_q.src);
          s_d.sleep_continue_bit = PWDATA[RMSC_SLEEP_CONTINUE_BIT_LSB +: 4];
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (PADDR)
        RMSC_ADDR_MODE: s_d.rdata = {29'h0, s_q.mode};
        RMSC_ADDR_PUMP: s_d.rdata = {30'h0, s_q.pump};
        RMSC_ADDR_FLAG: s_d.rdata = {31'h0, s_q.flag};
        RMSC_ADDR_IEN: s_d.rdata = {31'h0, s_q.ien};
        RMSC_ADDR_SCLK: s_d.rdata = {16'h0, s_q.wake_en, 1'b0, s_q.wdiv,
                                     2'h0, s_q.wsrc, 2'h0, s_q.div,
                                     2'h0, s_q.src};
        RMSC_ADDR_PROT: s_d.rdata = {31'h0, s_q.unlocked};
        RMSC_ADDR_OSC: s_d.rdata = {20'h0, s_q.sleep_continue_bit, 4'h0, s_q.osc_en};
        RMSC_ADDR_STAT: s_d.rdata = {24'h0, cur_div, cur_src, 1'b0,
                                     s_q.eff};
        default: s_d.rdata = '0;
      endcase
    end
    // Sleep and wake-up
    if (SLEEP_ENTER) begin
      s_d.asleep = 1'b1;
    end
    if (WAKE_UP && s_q.asleep) begin
      s_d.asleep = 1'b0;
      if (s_q.wake_en) begin
        s_d.src = s_q.wsrc;
        s_d.div = s_q.wdiv;
        s_d.osc_en = s_q.osc_en | onehot(s_q.wsrc);
        s_d.wake_fix = 1'b1;
      end
    end
    // Trim enables one cycle later, once the new source is settled
    if (s_q.wake_fix) begin
      s_d.wake_fix = 1'b0;
      s_d.osc_en = s_q.osc_en & (onehot(s_q.src) | ~s_q.sleep_continue_bit);
    end
    // Regulator transition tracking
    case (s_q.tr)
      RMSC_IDLE: begin
        if (nm != s_q.eff) begin
          s_d.tr = RMSC_SETTLE;
          s_d.tr_cnt = '0;
          s_d.from_seco = (s_q.eff == RMSC_MODE_SECO);
          s_d.eff = nm;
        end
      end
      RMSC_SETTLE: begin
        if (s_q.tr_cnt == 8'(SETTLE - 1)) begin
          s_d.tr = RMSC_IDLE;
          done_ev = s_q.from_seco || (s_q.mode == RMSC_MODE_AUTO &&
                                      s_q.eff == RMSC_MODE_ECO);
        end else begin
          s_d.tr_cnt = s_q.tr_cnt + 8'h1;
        end
      end
      default: s_d.tr = RMSC_IDLE;
    endcase
    // Set wins over a same-cycle clear
    if (wr && PADDR == RMSC_ADDR_FLAG && PWDATA[0]) begin
      s_d.flag = 1'b0;
    end
    if (done_ev) begin
      s_d.flag = 1'b1;
    end
    s_d.irq = s_d.flag && s_d.ien;
    // Charge pump tick from the slow crystal tick
    case (s_q.pump)
      2'h0: pmask = 8'h1f;
      2'h1: pmask = 8'h3f;
      2'h2: pmask = 8'h7f;
      default: pmask = 8'hff;
    endcase
    s_d.ptick = 1'b0;
    if (SRC_TICK[RMSC_SRC_OSC1]) begin
      s_d.pcnt = s_q.pcnt + 8'h1;
      if ((s_q.pcnt & pmask) == pmask) begin
        s_d.ptick = 1'b1;
        s_d.pcnt = '0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      s_q <= '0;
      s_q.osc_en <= RMSC_OSC_EN_RST;
      s_q.sleep_continue_bit <= RMSC_SLEEP_CONTINUE_BIT_RST;
      s_q.eff <= RMSC_MODE_ECO;
      s_q.tr <= RMSC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PRDATA = s_q.rdata;
  assign PREADY = s_q.ready;
  assign PSLVERR = s_q.err;
  assign SYS_TICK = sys_tick;
  assign PUMP_TICK = s_q.ptick;
  assign REG_MODE = s_q.eff;
  assign OSC_ENABLE = s_q.osc_en;
  assign IRQ = s_q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_mode_legal: assert property (@(posedge CLOCK) disable iff (!NRST)
    s_q.mode inside {3'h0, 3'h2, 3'h3, 3'h5})
    else $error("Mode field holds reserved code");
  chk_mode_resv: assert property (@(posedge CLOCK) disable iff (!NRST)
    (PSEL && PENABLE && !PREADY && PWRITE && s_q.unlocked &&
     PADDR == RMSC_ADDR_MODE && PWDATA[2:0] == 3'h1) |=> s_q.mode == 3'h0)
    else $error("Reserved mode not stored as automatic");
  chk_irq_gate: assert property (@(posedge CLOCK) disable iff (!NRST)
    IRQ |-> s_q.flag && s_q.ien)
    else $error("Interrupt without enabled flag");
  // Same cycle: a set flag with the enable on raises the request at once
  chk_irq_en: assert property (@(posedge CLOCK) disable iff (!NRST)
    (s_q.flag && s_q.ien) |-> IRQ)
    else $error("Enabled flag did not raise interrupt");
  chk_flag_clr: assert property (@(posedge CLOCK) disable iff (!NRST)
    (PSEL && PENABLE && !PREADY && PWRITE && PADDR == RMSC_ADDR_FLAG &&
     PWDATA[0] && !(s_q.tr == RMSC_SETTLE)) |=> !s_q.flag)
    else $error("Flag not cleared by write one");
  chk_wake_load: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WAKE_UP && s_q.asleep && s_q.wake_en) |=>
    s_q.src == $past(s_q.wsrc) && s_q.div == $past(s_q.wdiv))
    else $error("Wake-up did not load source and divider");
  chk_wake_keep: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WAKE_UP && s_q.asleep && !s_q.wake_en && !(PSEL && PWRITE)) |=>
    $stable(s_q.src) && $stable(s_q.div))
    else $error("Wake-up altered source with switch off");
  chk_wake_start: assert property (@(posedge CLOCK) disable iff (!NRST)
    (WAKE_UP && s_q.asleep && s_q.wake_en) |=> OSC_ENABLE[s_q.src])
    else $error("Wake-up source not started");
  chk_wake_trim: assert property (@(posedge CLOCK) disable iff (!NRST)
    s_q.wake_fix |=> (OSC_ENABLE & ~onehot(s_q.src) & s_q.sleep_continue_bit) == 4'h0)
    else $error("Unused sources left running after wake-up");
  chk_sel_start: assert property (@(posedge CLOCK) disable iff (!NRST)
    !s_q.wake_fix |-> OSC_ENABLE[s_q.src])
    else $error("Selected source is stopped");
endmodule : rmsc_top
`default_nettype wire

/* File: verif/rmsc_bench.sv */
// Self-checking bench for the regulator mode and clock select block.
// Assumes rmsc_pkg and rmsc_top are compiled first; bench is APB master.
`timescale 1ns/1ps
`default_nettype none
module rmsc_bench
  import rmsc_pkg::*;
;
  // ****************************************************************
  // Stimulus and design instance
  // ****************************************************************
  // Short settle keeps regulator transitions quick in simulation
  localparam int SET = 8;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_enter = 1'b0;
  logic wake_up = 1'b0;
  logic hsr = 1'b0;
  // Every source ticks each cycle so divider ratios show as periods
  logic [3:0] src_tick = 4'hf;
  logic [3:0] osc_en;
  logic sys_tick;
  logic pump_tick;
  logic irq;
  logic [2:0] reg_mode;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] r;
  always #12.5 clock = ~clock;
  rmsc_top #(.SETTLE(SET)) rmsc_top_i (.CLOCK(clock), .NRST(nrst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SLEEP_ENTER(sleep_enter), .WAKE_UP(wake_up),
    .HIGH_SPEED_RUN(hsr), .SRC_TICK(src_tick), .SYS_TICK(sys_tick),
    .PUMP_TICK(pump_tick), .REG_MODE(reg_mode), .OSC_ENABLE(osc_en),
    .IRQ(irq));
  // ****************************************************************
  // Tasks and expectation functions
  // ****************************************************************
  task automatic check(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // Holds the request until PREADY is seen high; gives up after 40 cycles and counts a mismatch
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) check("pready", 32'h0, 32'h1);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdchk(input string n, input logic [11:0] a,
                       input logic [31:0] x);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(n, r, x);
  endtask : rdchk
  // Polls a register field; running out of tries counts as a mismatch
  task automatic wait_reg(input logic [11:0] a, input logic [31:0] m, x);
    int n;
    logic e;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0, r, e);
      n++;
    end while ((r & m) !== x && n < 200);
    if (n >= 200) check("poll", r & m, x);
  endtask : wait_reg
  task automatic period(input bit pump, output int p);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((pump ? pump_tick : sys_tick) !== 1'b1 && n < 600);
    p = 0;
    do begin
      @(posedge clock);
      p++;
    end while ((pump ? pump_tick : sys_tick) !== 1'b1 && p < 600);
  endtask : period
  task automatic settle();
    @(posedge clock);
    #1;
  endtask : settle
  task automatic nap();
    @(posedge clock);
    sleep_enter <= 1'b1;
    @(posedge clock);
    sleep_enter <= 1'b0;
    repeat (4) @(posedge clock);
    wake_up <= 1'b1;
    @(posedge clock);
    wake_up <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : nap
  function automatic int ratio(input int s, input int c);
    if (s == 2 && c > 1) return 1 << (c + 1);
    return (s == 3) ? 1 : 1 << c;
  endfunction : ratio
  function automatic logic [31:0] mode_exp(input int v);
    return (v == 5 || v == 3 || v == 2) ? 32'(v) : 32'h0;
  endfunction : mode_exp
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (80000) @(posedge clock);
    check("watchdog", 32'h0, 32'h1);
    report_and_stop();
  end
  initial begin
    int p;
    logic e;
    logic [31:0] d;
    void'($urandom(3416));
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rdchk("mode", RMSC_ADDR_MODE, 32'h0);
    rdchk("pump", RMSC_ADDR_PUMP, 32'h0);
    rdchk("flag", RMSC_ADDR_FLAG, 32'h0);
    rdchk("ien", RMSC_ADDR_IEN, 32'h0);
    rdchk("sclk", RMSC_ADDR_SCLK, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    $display("test reset done");
    wr(RMSC_ADDR_MODE, 32'h5);
    rdchk("locked", RMSC_ADDR_MODE, 32'h0);
    wr(RMSC_ADDR_PROT, {16'h0, RMSC_UNLOCK_KEY});
    for (int v = 0; v < 8; v++) begin
      d = $urandom();
      wr(RMSC_ADDR_MODE, {d[31:3], 3'(v)});
      rdchk("mode", RMSC_ADDR_MODE, mode_exp(v));
    end
    $display("test mode codes done");
    wr(RMSC_ADDR_OSC, 32'h0f03);
    for (int c = 0; c < 4; c++) begin
      d = $urandom();
      wr(RMSC_ADDR_PUMP, {d[31:2], 2'(c)});
      rdchk("pump", RMSC_ADDR_PUMP, 32'(c));
      period(1'b1, p);
      period(1'b1, p);
      check("pump_period", 32'(p), 32'(32 << c));
    end
    $display("test pump divider done");
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        if ((s == 1 && c > 1) || (s == 3 && c > 0)) continue;
        wr(RMSC_ADDR_SCLK, 32'((c << 4) | s));
        wait_reg(RMSC_ADDR_STAT, 32'hf0, 32'((c << 6) | (s << 4)));
        check("auto_start", {31'h0, osc_en[s]}, 32'h1);
        period(1'b0, p);
        period(1'b0, p);
        check("sys_period", 32'(p), 32'(ratio(s, c)));
      end
    end
    $display("test clock select done");
    wr(RMSC_ADDR_MODE, 32'h5);
    wait_reg(RMSC_ADDR_STAT, 32'h7, 32'h5);
    wr(RMSC_ADDR_FLAG, 32'h1);
    wr(RMSC_ADDR_MODE, 32'h2);
    wait_reg(RMSC_ADDR_FLAG, 32'h1, 32'h1);
    check("reg_mode", {29'h0, reg_mode}, 32'h2);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(RMSC_ADDR_IEN, 32'h1);
    settle();
    check("irq_on", {31'h0, irq}, 32'h1);
    wr(RMSC_ADDR_FLAG, 32'h0);
    rdchk("flag_kept", RMSC_ADDR_FLAG, 32'h1);
    wr(RMSC_ADDR_FLAG, 32'h1);
    rdchk("flag_clr", RMSC_ADDR_FLAG, 32'h0);
    settle();
    check("irq_off", {31'h0, irq}, 32'h0);
    wr(RMSC_ADDR_IEN, 32'h0);
    hsr <= 1'b1;
    wr(RMSC_ADDR_MODE, 32'h0);
    wait_reg(RMSC_ADDR_STAT, 32'h7, 32'h2);
    wr(RMSC_ADDR_FLAG, 32'h1);
    hsr <= 1'b0;
    wait_reg(RMSC_ADDR_FLAG, 32'h1, 32'h1);
    check("auto_eco", {29'h0, reg_mode}, 32'h3);
    wr(RMSC_ADDR_FLAG, 32'h1);
    $display("test interrupt done");
    wr(RMSC_ADDR_SCLK, 32'hb200);
    wait_reg(RMSC_ADDR_STAT, 32'hf0, 32'h0);
    wr(RMSC_ADDR_OSC, 32'h0e03);
    nap();
    rdchk("wake_sclk", RMSC_ADDR_SCLK, 32'hb232);
    rdchk("wake_osc", RMSC_ADDR_OSC, 32'h0e05);
    check("osc_en", {28'h0, osc_en}, 32'h5);
    wr(RMSC_ADDR_SCLK, 32'h0310);
    wait_reg(RMSC_ADDR_STAT, 32'hf0, 32'h40);
    nap();
    rdchk("still_sclk", RMSC_ADDR_SCLK, 32'h0310);
    $display("test wake switch done");
    apb(1'b0, 12'h020, 32'h0, r, e);
    check("slverr", {31'h0, e}, 32'h1);
    $display("test unmapped done");
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rdchk("sclk_rst", RMSC_ADDR_SCLK, 32'h0);
    rdchk("osc_rst", RMSC_ADDR_OSC, 32'h0f01);
    check("osc_en_rst", {28'h0, osc_en}, 32'h1);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : rmsc_bench
`default_nettype wire
